/* File: pin_activity_monitor_consts.vh */
// Constants for the pin activity monitor: register addresses, widths and reset values
`ifndef PIN_ACTIVITY_MONITOR_CONSTS_VH
`define PIN_ACTIVITY_MONITOR_CONSTS_VH

// ************************************************************
// Widths
// ************************************************************
`define MON_PIN_COUNT 8
`define MON_SFR_ADDR_W 8
`define MON_SYNC_W 10

// ************************************************************
// Special function register addresses
// ************************************************************
`define MON_ADDR_ENABLE 8'h92
`define MON_ADDR_QUALIFY 8'h93
`define MON_ADDR_POLARITY 8'h94
`define MON_ADDR_FLAGS 8'h95

// ************************************************************
// Reset and fixed values
// ************************************************************
`define MON_RESET_BYTE 8'h00
`define MON_UNMAPPED_READ 8'h00
`define MON_ZERO_BIT 1'h0
`define MON_STROBE_IDLE 2'h3

// ************************************************************
// Position of the host strobes in the synchroniser vector
// ************************************************************
`define MON_SYNC_RD_BIT 8
`define MON_SYNC_WR_BIT 9

`endif

/* File: level_sync.v */
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps

module level_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire arst_n,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    // First stage feeds only the second stage
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RESET_VAL;
            stable_r <= RESET_VAL;
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule // level_sync

/* File: pin_activity_monitor.v */
// Pin activity monitor: enable, qualify, polarity and sticky flag registers on the SFR bus
`timescale 1ns/1ps
`include "pin_activity_monitor_consts.vh"

module pin_activity_monitor (
    input wire clock,
    input wire arst_n,
    input wire [`MON_PIN_COUNT-1:0] monitor_input_pin,
    input wire host_io_read_strobe_n,
    input wire host_io_write_strobe_n,
    input wire [`MON_SFR_ADDR_W-1:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [`MON_PIN_COUNT-1:0] sfr_wdata,
    output wire [`MON_PIN_COUNT-1:0] sfr_rdata,
    output wire sfr_hit,
    input wire monitor_irq_global_enable,
    input wire monitor_irq_priority,
    output wire [`MON_PIN_COUNT-1:0] port_input_level,
    output wire monitor_irq_req,
    output wire monitor_irq_high_priority
);

    // ************************************************************
    // Declarations
    // ************************************************************
    // Registered state and the next-state values of the flag and read data registers
    reg [`MON_PIN_COUNT-1:0] monitor_enable_bits_r;
    reg [`MON_PIN_COUNT-1:0] monitor_qualify_bits_r;
    reg [`MON_PIN_COUNT-1:0] monitor_polarity_bits_r;
    reg [`MON_PIN_COUNT-1:0] monitor_flag_bits_r;
    reg [`MON_PIN_COUNT-1:0] monitor_flag_bits_nxt;
    reg [`MON_PIN_COUNT-1:0] rdata_r;
    reg [`MON_PIN_COUNT-1:0] rdata_nxt;
    reg irq_req_r;
    reg irq_prio_r;
    // Combinational nets
    wire [`MON_SYNC_W-1:0] raw_inputs;
    wire [`MON_SYNC_W-1:0] synced_inputs;
    wire [`MON_PIN_COUNT-1:0] pin_level;
    wire strobe_rd_n;
    wire strobe_wr_n;
    wire host_strobe_active;
    wire [`MON_PIN_COUNT-1:0] pin_valid;
    wire [`MON_PIN_COUNT-1:0] pin_detect;
    wire sel_enable;
    wire sel_qualify;
    wire sel_polarity;
    wire sel_flags;

    // ************************************************************
    // Input synchronisation
    // ************************************************************

    // Pins and active-low strobes share one synchroniser; strobes idle high
    assign raw_inputs = {host_io_write_strobe_n, host_io_read_strobe_n, monitor_input_pin};

    // Strobes reset to idle so no false qualification follows reset
    level_sync #(
        .WIDTH(`MON_SYNC_W),
        .RESET_VAL({`MON_STROBE_IDLE, `MON_RESET_BYTE})
    ) u_input_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async_in(raw_inputs),
        .sync_out(synced_inputs)
    );

    // Split the synchroniser vector back into pins and strobes
    assign pin_level = synced_inputs[`MON_PIN_COUNT-1:0];
    assign strobe_rd_n = synced_inputs[`MON_SYNC_RD_BIT];
    assign strobe_wr_n = synced_inputs[`MON_SYNC_WR_BIT];

    // Port input path always shows the synchronised pin level
    assign port_input_level = pin_level;

    // ************************************************************
    // Detection
    // ************************************************************

    // Either strobe low counts as a valid host access
    assign host_strobe_active = ~strobe_rd_n | ~strobe_wr_n;

    // Valid state is the level equal to the polarity bit
    assign pin_valid = ~(pin_level ^ monitor_polarity_bits_r);

    // Qualified pins also need a coincident host strobe; only enabled pins detect
    assign pin_detect = monitor_enable_bits_r & pin_valid
                        & (~monitor_qualify_bits_r | {`MON_PIN_COUNT{host_strobe_active}});

    // ************************************************************
    // Register decode
    // ************************************************************
    // One select per mapped address; the hit flag covers all four
    assign sel_enable = (sfr_addr == `MON_ADDR_ENABLE);
    assign sel_qualify = (sfr_addr == `MON_ADDR_QUALIFY);
    assign sel_polarity = (sfr_addr == `MON_ADDR_POLARITY);
    assign sel_flags = (sfr_addr == `MON_ADDR_FLAGS);
    assign sfr_hit = sel_enable | sel_qualify | sel_polarity | sel_flags;

    // ************************************************************
    // Control registers
    // ************************************************************

    // Plain read/write byte registers
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            monitor_enable_bits_r <= `MON_RESET_BYTE;
            monitor_qualify_bits_r <= `MON_RESET_BYTE;
            monitor_polarity_bits_r <= `MON_RESET_BYTE;
        end else if (sfr_wr) begin
            if (sel_enable) begin
                monitor_enable_bits_r <= sfr_wdata;
            end
            if (sel_qualify) begin
                monitor_qualify_bits_r <= sfr_wdata;
            end
            if (sel_polarity) begin
                monitor_polarity_bits_r <= sfr_wdata;
            end
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************

    // A zero written clears, a one keeps; a detection always wins over the clear
    // Set wins so an event in the clearing cycle is never lost
    // Firmware clears one flag by writing zero there and ones elsewhere
    always @* begin
        monitor_flag_bits_nxt = monitor_flag_bits_r;
        if (sfr_wr && sel_flags) begin
            monitor_flag_bits_nxt = monitor_flag_bits_r & sfr_wdata;
        end
        monitor_flag_bits_nxt = monitor_flag_bits_nxt | pin_detect;
    end

    // Flag register; every reset kind clears it
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            monitor_flag_bits_r <= `MON_RESET_BYTE;
        end else begin
            monitor_flag_bits_r <= monitor_flag_bits_nxt;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************

    // Read data registered on the read strobe; unmapped addresses return zero
    always @* begin
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            case (1'b1)
                sel_enable: begin
                    rdata_nxt = monitor_enable_bits_r;
                end
                sel_qualify: begin
                    rdata_nxt = monitor_qualify_bits_r;
                end
                sel_polarity: begin
                    rdata_nxt = monitor_polarity_bits_r;
                end
                sel_flags: begin
                    rdata_nxt = monitor_flag_bits_r;
                end
                default: begin
                    rdata_nxt = `MON_UNMAPPED_READ;
                end
            endcase
        end
    end

    // Read data flip-flops
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= `MON_RESET_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Read data straight from its flip-flops
    assign sfr_rdata = rdata_r;

    // ************************************************************
    // Interrupt request
    // ************************************************************

    // Only flags of enabled pins count; global enable gates the whole request
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_req_r <= `MON_ZERO_BIT;
            irq_prio_r <= `MON_ZERO_BIT;
        end else begin
            irq_req_r <= monitor_irq_global_enable
                         & (|(monitor_flag_bits_r & monitor_enable_bits_r));
            irq_prio_r <= monitor_irq_priority;
        end
    end

    // Request and priority leave from flip-flops
    assign monitor_irq_req = irq_req_r;
    assign monitor_irq_high_priority = irq_prio_r;

endmodule // pin_activity_monitor

/* File: pin_activity_monitor_sva.sv */
// Port-level checker of the pin activity monitor
`timescale 1ns/1ps
module pin_activity_monitor_sva (
    input wire clock,
    input wire arst_n,
    input wire [7:0] monitor_input_pin,
    input wire host_io_read_strobe_n,
    input wire host_io_write_strobe_n,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire monitor_irq_global_enable,
    input wire monitor_irq_priority,
    input wire [7:0] port_input_level,
    input wire monitor_irq_req,
    input wire monitor_irq_high_priority
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // A pin held still for three edges shows up unchanged on the input path
    property p_level; $stable(monitor_input_pin)[*3] |-> port_input_level == monitor_input_pin;
    endproperty
    a_level: assert property (p_level) else $error("input path level wrong");
    property p_hit; sfr_hit == (sfr_addr >= 8'h92 && sfr_addr <= 8'h95); endproperty
    a_hit: assert property (p_hit) else $error("decode wrong");
    property p_unmap; sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // Control registers read back what was written two edges before
    property p_back; sfr_wr && sfr_addr >= 8'h92 && sfr_addr <= 8'h94
        ##2 sfr_rd && sfr_addr == $past(sfr_addr, 2) |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    a_back: assert property (p_back) else $error("register readback wrong");
    property p_geoff; !monitor_irq_global_enable |=> !monitor_irq_req; endproperty
    a_geoff: assert property (p_geoff) else $error("request without enable");
    property p_rise; $rose(monitor_irq_req) |-> $past(monitor_irq_global_enable); endproperty
    a_rise: assert property (p_rise) else $error("request rose unenabled");
    property p_prio; 1'b1 |=> monitor_irq_high_priority == $past(monitor_irq_priority);
    endproperty
    a_prio: assert property (p_prio) else $error("priority not followed");
    // An empty flag read means no request can stand
    property p_empty; sfr_rd && sfr_addr == 8'h95 ##1 sfr_rdata == 8'h00 |-> !monitor_irq_req;
    endproperty
    a_empty: assert property (p_empty) else $error("request without flag");
endmodule // pin_activity_monitor_sva

bind pin_activity_monitor pin_activity_monitor_sva u_sva (.clock(clock), .arst_n(arst_n),
    .monitor_input_pin(monitor_input_pin), .host_io_read_strobe_n(host_io_read_strobe_n),
    .host_io_write_strobe_n(host_io_write_strobe_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .monitor_irq_global_enable(monitor_irq_global_enable),
    .monitor_irq_priority(monitor_irq_priority), .port_input_level(port_input_level),
    .monitor_irq_req(monitor_irq_req), .monitor_irq_high_priority(monitor_irq_high_priority));

/* File: peripheral_side.sv */
// Far-side model: peripheral chip selects and host IO strobes
`timescale 1ns/1ps
module peripheral_side (
    input wire [7:0] cs_level,
    input wire rd_req,
    input wire wr_req,
    output reg [7:0] monitor_input_pin,
    output reg host_io_read_strobe_n,
    output reg host_io_write_strobe_n
);
    // Latch left at one, so each pin follows its chip select; strobes are active low
    always @* begin
        monitor_input_pin = cs_level;
        host_io_read_strobe_n = ~rd_req;
        host_io_write_strobe_n = ~wr_req;
    end
endmodule // peripheral_side

/* File: tb_pin_activity_monitor.sv */
// Self-checking bench of the pin activity monitor
`timescale 1ns/1ps
module tb_pin_activity_monitor;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg [7:0] cs = 8'hFF;
    reg rd_req = 1'b0;
    reg wr_req = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg sfr_wr = 1'b0;
    reg sfr_rd = 1'b0;
    reg ge = 1'b1;
    reg prio = 1'b0;
    wire [7:0] pins, rdata, level;
    wire rd_n, wr_n, hit, irq, hprio;
    integer fails = 0;
    integer tests_run = 0;
    integer i;
    peripheral_side u_peer (.cs_level(cs), .rd_req(rd_req), .wr_req(wr_req),
        .monitor_input_pin(pins), .host_io_read_strobe_n(rd_n), .host_io_write_strobe_n(wr_n));
    pin_activity_monitor u_dut (.clock(clock), .arst_n(arst_n), .monitor_input_pin(pins),
        .host_io_read_strobe_n(rd_n), .host_io_write_strobe_n(wr_n), .sfr_addr(addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_hit(hit),
        .monitor_irq_global_enable(ge), .monitor_irq_priority(prio), .port_input_level(level),
        .monitor_irq_req(irq), .monitor_irq_high_priority(hprio));
    // Core clock, 100 ns period
    initial begin
        forever #50 clock = ~clock;
    end
    task check(input [8*5-1:0] name, input [7:0] exp, input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock);
            addr = a;
            wdata = d;
            sfr_wr = 1'b1;
            @(negedge clock);
            sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(negedge clock);
            addr = a;
            sfr_rd = 1'b1;
            @(negedge clock);
            sfr_rd = 1'b0;
            check("rdata", e, rdata);
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Test sequence
    initial begin
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        wr(8'h96, 8'hFF);
        for (i = 0; i < 5; i = i + 1) rd(8'h92 + i, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h92 + i, 8'h5A);
            rd(8'h92 + i, 8'h5A);
        end
        wr(8'h94, 8'h00);
        wr(8'h93, 8'h00);
        wr(8'h92, 8'hFF);
        wr(8'h95, 8'h00);
        rd(8'h95, 8'h00);
        $display("test registers done");
        cs = 8'hFE;
        repeat (2) @(negedge clock);
        check("level", 8'hFE, level);
        repeat (2) @(negedge clock);
        rd(8'h95, 8'h01);
        check("irq", 8'h01, {7'h00, irq});
        cs = 8'hFF;
        prio = 1'b1;
        repeat (4) @(negedge clock);
        rd(8'h95, 8'h01);
        check("prio", 8'h01, {7'h00, hprio});
        wr(8'h95, 8'hFF);
        rd(8'h95, 8'h01);
        wr(8'h95, 8'hFE);
        rd(8'h95, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
        wr(8'h94, 8'h02);
        repeat (3) @(negedge clock);
        rd(8'h95, 8'h02);
        wr(8'h94, 8'h00);
        wr(8'h95, 8'h00);
        $display("test detection done");
        wr(8'h93, 8'h04);
        cs = 8'hFB;
        repeat (4) @(negedge clock);
        rd(8'h95, 8'h00);
        rd_req = 1'b1;
        repeat (4) @(negedge clock);
        rd_req = 1'b0;
        rd(8'h95, 8'h04);
        wr(8'h95, 8'h00);
        rd(8'h95, 8'h00);
        wr_req = 1'b1;
        repeat (4) @(negedge clock);
        wr_req = 1'b0;
        rd(8'h95, 8'h04);
        cs = 8'hFF;
        repeat (3) @(negedge clock);
        wr(8'h93, 8'h00);
        wr(8'h95, 8'h00);
        $display("test qualify done");
        wr(8'h92, 8'hFE);
        cs = 8'hFE;
        repeat (4) @(negedge clock);
        rd(8'h95, 8'h00);
        wr(8'h92, 8'hFF);
        ge = 1'b0;
        repeat (4) @(negedge clock);
        check("irq", 8'h00, {7'h00, irq});
        rd(8'h95, 8'h01);
        ge = 1'b1;
        repeat (2) @(negedge clock);
        check("irq", 8'h01, {7'h00, irq});
        wr(8'h95, 8'h00);
        @(negedge clock);
        check("irq", 8'h01, {7'h00, irq});
        rd(8'h95, 8'h01);
        $display("test enables done");
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        for (i = 0; i < 4; i = i + 1) rd(8'h92 + i, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
        $display("test reset done");
        give_verdict;
    end
    // Watchdog against a hung sequence
    initial begin
        #100000;
        fails = fails + 1;
        give_verdict;
    end
endmodule // tb_pin_activity_monitor
